/* rtl/pis_pkg.sv */
// constants and types of the peripheral interrupt source collector
package pis_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] PIS_FLAGS_LO_ADDR  = 8'h00;
	localparam logic [7:0] PIS_FLAGS_HI_ADDR  = 8'h04;
	localparam logic [7:0] PIS_ENABLE_LO_ADDR = 8'h08;
	localparam logic [7:0] PIS_ENABLE_HI_ADDR = 8'h0c;
	localparam logic [7:0] PIS_CONTROL_ADDR   = 8'h10;
	localparam logic [7:0] PIS_GROUPS_ADDR    = 8'h14;

	// control register fields
	localparam int PIS_CTL_RATE_LSB   = 0;
	localparam int PIS_CTL_DETECT_BIT = 3;
	localparam int PIS_CTL_NINE_BIT   = 4;
	localparam int PIS_CTL_ACK_BIT    = 5;
	localparam logic [2:0] PIS_RATE_RESET = 3'h0;

	// ==========================================================
	// flag vector layout, grouped by request line
	localparam int PIS_NFLAGS = 34;
	localparam int PIS_NGROUPS = 20;
	localparam int F_EXT = 0, F_LOCK = 1, F_T1C0 = 2, F_T1C1 = 3, F_T1W = 4;
	localparam int F_T2C0 = 5, F_T2C1 = 6, F_T2W = 7;
	localparam int F_SRX = 8, F_SOVF = 9, F_SFLT = 10, F_STX = 11;
	localparam int F_AOVR = 12, F_ANF = 13, F_AFE = 14, F_APE = 15;
	localparam int F_ARX = 16, F_IDLE = 17, F_ATX = 18, F_ADONE = 19;
	localparam int F_KEY = 20, F_CONV = 21, F_TICK = 22, F_CWAKE = 23;
	localparam int F_CRXW = 24, F_CTXW = 25, F_CRXP = 26, F_CTXP = 27;
	localparam int F_CBOFF = 28, F_COVR = 29, F_CRX = 30, F_CTX0 = 31;

	// first and last flag of each request group, group 1 to 20
	localparam int PIS_GRP_FIRST [1:20] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11,
		12, 16, 18, 20, 21, 22, 23, 24, 30, 31};
	localparam int PIS_GRP_LAST [1:20] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11,
		15, 17, 19, 20, 21, 22, 23, 29, 30, 33};
	localparam logic [4:0] PIS_PRIO_TOP  = 5'h0;
	localparam logic [4:0] PIS_PRIO_NONE = 5'h1f;

	// ==========================================================
	// timing and limits
	localparam logic [3:0] PIS_IDLE_BITS      = 4'ha;
	localparam logic [3:0] PIS_IDLE_BITS_LONG = 4'hb;
	localparam logic [7:0] PIS_CAN_WARN       = 8'h60;
	localparam logic [7:0] PIS_CAN_PASSIVE    = 8'h7f;
	localparam logic [8:0] PIS_CAN_BUS_OFF    = 9'h0ff;
	localparam logic [15:0] PIS_TICK_FULL     = 16'hffff;

	// ==========================================================
	// peripheral events and levels, all on ref_clk
	typedef struct packed {
		logic              lock;
		logic [1:0][15:0]  timer_count;
		logic [1:0][15:0]  timer_modulo;
		logic [1:0][1:0]   channel_event;
		logic              sync_byte_done;
		logic              sync_tx_load;
		logic              sync_master;
		logic              sync_active;
		logic              async_tx_load;
		logic              async_shift_empty;
		logic              async_data_empty;
		logic              async_break_idle;
		logic              async_char_done;
		logic              async_bit_tick;
		logic              async_stop_sample;
		logic              async_stop_bit;
		logic              async_noise;
		logic              async_parity_err;
		logic              conversion_done;
		logic [2:0]        can_tx_empty;
		logic              can_msg_stored;
		logic              can_wake_activity;
		logic              can_fg_full;
		logic              can_bg_full;
		logic              can_msg_arriving;
		logic [7:0]        can_rx_errors;
		logic [8:0]        can_tx_errors;
	} pis_periph_t;

endpackage : pis_pkg

/* rtl/pis_top.sv */
// peripheral interrupt source collector
// Behaviour
// RULE1: global mask blocks all but software trap
// RULE2: lower priority number wins, trap is 0
// RULE3: low on request or keypad pin latches
// RULE4: lock change sets lock change flag
// RULE5: timer wrap to zero after modulo sets flag
// RULE6: channel capture or compare sets channel flag
// RULE7: sync byte into receive register sets full
// RULE8: sync byte into shifter sets tx empty
// RULE9: select fault by role when detection on
// RULE10: sync overflow on unread byte; shared enable
// RULE11: async data handed to shifter sets empty
// RULE12: async done when both empty, no break
// RULE13: async character to data register sets full
// RULE14: idle after 10 or 11 high bits
// RULE15: async overrun on unread previous character
// RULE16: framing, noise, parity flags each enabled
// RULE17: conversion request replaces done bit when enabled
// RULE18: tick rollover at selected rate sets flag
// RULE19: writing acknowledge clears the tick flag
// RULE20: can buffer empty and receive full flags
// RULE21: can wake and overrun flags
// RULE22: can warning 96, passive 127, bus off 255
// RULE23: group status reads gated pending request
// RULE24: group request ORs pairs, gated by mask; the code ORs groups of one to six flags each
// RULE25: flags hold until their clearing action
//
// The register offsets and strobed register access are this design's own decisions.
module pis_top (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	// register port
	input  wire logic [7:0]               reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_write,
	input  wire logic                     reg_read,
	output logic [31:0]                   reg_rdata,
	// pins
	input  wire logic                     ext_request_n,
	input  wire logic [7:0]               keypad_inputs,
	input  wire logic                     select_in_n,
	input  wire logic                     async_rx_pin,
	// peripherals
	input  pis_pkg::pis_periph_t          periph,
	// processor core
	input  wire logic                     global_mask,
	input  wire logic                     software_trap,
	output logic                          cpu_request,
	output logic [4:0]                    cpu_priority,
	output logic [pis_pkg::PIS_NGROUPS:1] group_pending,
	output logic                          conversion_done_bit
);
	import pis_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic [10:0] pin_s1;
	logic [10:0] pin_s2;
	logic        select_prev;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_s1 <= 11'h7ff;
			pin_s2 <= 11'h7ff;
		end else begin
			pin_s1 <= {async_rx_pin, select_in_n, keypad_inputs, ext_request_n};
			pin_s2 <= pin_s1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			select_prev <= 1'b1;
		else
			select_prev <= pin_s2[9];
	end

	// ==========================================================
	// control registers
	logic [PIS_NFLAGS-1:0] enable;
	logic [2:0]            tick_rate_select;
	logic                  select_fault_detect_on;
	logic                  async_nine_bit;
	logic                  tick_acknowledge;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			enable                 <= '0;
			tick_rate_select       <= PIS_RATE_RESET;
			select_fault_detect_on <= 1'b0;
			async_nine_bit         <= 1'b0;
		end else if (reg_write) begin
			case (reg_addr)
				PIS_ENABLE_LO_ADDR: enable[31:0] <= reg_wdata;
				PIS_ENABLE_HI_ADDR: enable[PIS_NFLAGS-1:32] <= reg_wdata[1:0];
				PIS_CONTROL_ADDR: begin
					tick_rate_select       <= reg_wdata[PIS_CTL_RATE_LSB +: 3];
					select_fault_detect_on <= reg_wdata[PIS_CTL_DETECT_BIT];
					async_nine_bit         <= reg_wdata[PIS_CTL_NINE_BIT];
				end
				default: ;
			endcase
		end
	end

	assign tick_acknowledge = reg_write && reg_addr == PIS_CONTROL_ADDR
		&& reg_wdata[PIS_CTL_ACK_BIT];

	// ==========================================================
	// event history
	logic [1:0][15:0] timer_prev;
	logic             lock_prev;
	logic [4:0]       can_level_prev;
	logic [4:0]       can_level;

	assign can_level = {periph.can_tx_errors > PIS_CAN_BUS_OFF,
		periph.can_tx_errors > {1'b0, PIS_CAN_PASSIVE},
		periph.can_rx_errors > PIS_CAN_PASSIVE,
		periph.can_tx_errors >= {1'b0, PIS_CAN_WARN},
		periph.can_rx_errors >= PIS_CAN_WARN};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			timer_prev     <= '0;
			lock_prev      <= 1'b0;
			can_level_prev <= 5'h0;
		end else begin
			timer_prev     <= periph.timer_count;
			lock_prev      <= periph.lock;
			can_level_prev <= can_level;
		end
	end

	// ==========================================================
	// idle line counter
	logic [3:0] idle_count;
	logic [3:0] idle_target;
	logic       idle_hit;

	assign idle_target = async_nine_bit ? PIS_IDLE_BITS_LONG : PIS_IDLE_BITS;
	assign idle_hit = periph.async_bit_tick && pin_s2[10]
		&& idle_count == idle_target - 4'h1; // RULE14

	always_ff @(posedge ref_clk) begin
		if (reset)
			idle_count <= 4'h0;
		else if (periph.async_bit_tick) begin
			if (!pin_s2[10])
				idle_count <= 4'h0;
			else if (idle_count != idle_target)
				idle_count <= idle_count + 4'h1;
		end
	end

	// ==========================================================
	// periodic tick chain
	logic [15:0] tick_count;
	logic        tick_roll;

	assign tick_roll = &(tick_count | ~(PIS_TICK_FULL >> tick_rate_select)); // RULE18

	always_ff @(posedge ref_clk) begin
		if (reset)
			tick_count <= 16'h0;
		else
			tick_count <= tick_count + 16'h1;
	end

	// ==========================================================
	// flag set and clear
	logic [PIS_NFLAGS-1:0] flags;
	logic [PIS_NFLAGS-1:0] set_vec;
	logic [PIS_NFLAGS-1:0] clr_vec;
	logic [PIS_NFLAGS-1:0] next_flags;

	always_comb begin
		set_vec = '0;
		set_vec[F_EXT]  = !pin_s2[0]; // RULE3
		set_vec[F_KEY]  = !(&pin_s2[8:1]); // RULE3
		set_vec[F_LOCK] = periph.lock != lock_prev; // RULE4
		for (int t = 0; t < 2; t++) begin
			set_vec[F_T1C0 + 3 * t] = periph.channel_event[t][0]; // RULE6
			set_vec[F_T1C1 + 3 * t] = periph.channel_event[t][1]; // RULE6
			set_vec[F_T1W + 3 * t] = timer_prev[t] == periph.timer_modulo[t]
				&& periph.timer_count[t] == 16'h0; // RULE5
		end
		set_vec[F_SRX]  = periph.sync_byte_done && !flags[F_SRX]; // RULE7
		set_vec[F_SOVF] = periph.sync_byte_done && flags[F_SRX]; // RULE10
		set_vec[F_SFLT] = select_fault_detect_on && (periph.sync_master ? !pin_s2[9]
			: periph.sync_active && pin_s2[9] && !select_prev); // RULE9
		set_vec[F_STX]  = periph.sync_tx_load; // RULE8
		set_vec[F_AOVR] = periph.async_char_done && flags[F_ARX]; // RULE15
		set_vec[F_ANF]  = periph.async_noise; // RULE16
		set_vec[F_AFE]  = periph.async_stop_sample && !periph.async_stop_bit; // RULE16
		set_vec[F_APE]  = periph.async_parity_err; // RULE16
		set_vec[F_ARX]  = periph.async_char_done && !flags[F_ARX]; // RULE13
		set_vec[F_IDLE] = idle_hit; // RULE14
		set_vec[F_ATX]  = periph.async_tx_load; // RULE11
		set_vec[F_ADONE] = periph.async_shift_empty && periph.async_data_empty
			&& !periph.async_break_idle; // RULE12
		set_vec[F_CONV] = periph.conversion_done; // RULE17
		set_vec[F_TICK] = tick_roll; // RULE18
		set_vec[F_CWAKE] = periph.can_wake_activity; // RULE21
		set_vec[F_CRXW +: 5] = can_level & ~can_level_prev; // RULE22
		set_vec[F_COVR] = periph.can_msg_arriving && periph.can_fg_full
			&& periph.can_bg_full; // RULE21
		set_vec[F_CRX]  = periph.can_msg_stored; // RULE20
		set_vec[F_CTX0 +: 3] = periph.can_tx_empty; // RULE20
	end

	always_comb begin
		clr_vec = '0;
		if (reg_write && reg_addr == PIS_FLAGS_LO_ADDR)
			clr_vec[31:0] = reg_wdata;
		if (reg_write && reg_addr == PIS_FLAGS_HI_ADDR)
			clr_vec[PIS_NFLAGS-1:32] = reg_wdata[1:0];
		clr_vec[F_TICK] = tick_acknowledge; // RULE19
	end

	// set wins over clear; enables never touch the flags
	assign next_flags = (flags & ~clr_vec) | set_vec; // RULE25

	always_ff @(posedge ref_clk) begin
		if (reset)
			flags <= '0;
		else
			flags <= next_flags;
	end

	// ==========================================================
	// group requests and priority
	logic [PIS_NFLAGS-1:0]  gated;
	logic [PIS_NGROUPS:1]   next_groups;
	logic [4:0]             next_priority;
	logic                   next_request;

	always_comb begin
		gated = flags & enable;
		gated[F_SFLT] = flags[F_SFLT] && enable[F_SOVF]; // RULE10
	end

	always_comb begin
		next_groups = '0;
		for (int g = 1; g <= PIS_NGROUPS; g++) begin
			for (int i = 0; i < PIS_NFLAGS; i++) begin
				if (i >= PIS_GRP_FIRST[g] && i <= PIS_GRP_LAST[g])
					next_groups[g] = next_groups[g] | gated[i]; // RULE24
			end
		end
	end

	always_comb begin
		next_priority = PIS_PRIO_NONE;
		for (int g = PIS_NGROUPS; g >= 1; g--) begin
			if (next_groups[g] && !global_mask)
				next_priority = 5'(g); // RULE2
		end
		if (software_trap)
			next_priority = PIS_PRIO_TOP; // RULE2
	end

	assign next_request = software_trap || (|next_groups && !global_mask); // RULE1

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cpu_request   <= 1'b0;
			cpu_priority  <= PIS_PRIO_NONE;
			group_pending <= '0;
		end else begin
			cpu_request   <= next_request;
			cpu_priority  <= next_priority;
			group_pending <= next_groups; // RULE23
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			conversion_done_bit <= 1'b0;
		else
			conversion_done_bit <= flags[F_CONV] && !enable[F_CONV]; // RULE17
	end

	// ==========================================================
	// register read port
	always_ff @(posedge ref_clk) begin
		if (reset)
			reg_rdata <= 32'h0000_0000;
		else if (reg_read) begin
			case (reg_addr)
				PIS_FLAGS_LO_ADDR:  reg_rdata <= flags[31:0];
				PIS_FLAGS_HI_ADDR:  reg_rdata <= {30'h0, flags[PIS_NFLAGS-1:32]};
				PIS_ENABLE_LO_ADDR: reg_rdata <= enable[31:0];
				PIS_ENABLE_HI_ADDR: reg_rdata <= {30'h0, enable[PIS_NFLAGS-1:32]};
				PIS_CONTROL_ADDR:   reg_rdata <= {27'h0, async_nine_bit,
					select_fault_detect_on, tick_rate_select};
				PIS_GROUPS_ADDR:    reg_rdata <= {10'h0, conversion_done_bit,
					group_pending, 1'b0};
				default:            reg_rdata <= 32'h0000_0000;
			endcase
		end else
			reg_rdata <= 32'h0000_0000;
	end

	// ==========================================================
	// checks
	mask_blocks_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE1
		global_mask && !software_trap |=> !cpu_request)
		else $error("masked source reached the core");

	trap_first_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE2
		software_trap |=> cpu_request && cpu_priority == 5'h0)
		else $error("software trap not top priority");

	pin_latch_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE3
		!pin_s2[0] ##1 pin_s2[0] && !clr_vec[F_EXT] |=> flags[F_EXT])
		else $error("external request not held");

	lock_change_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE4
		periph.lock != lock_prev |=> flags[F_LOCK])
		else $error("lock change missed");

	timer_wrap_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
		timer_prev[1] == periph.timer_modulo[1] && periph.timer_count[1] == 16'h0
		|=> flags[F_T2W])
		else $error("second timer wrap missed");

	sync_overflow_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE10
		periph.sync_byte_done && flags[F_SRX] && !clr_vec[F_SRX]
		|=> flags[F_SOVF] && flags[F_SRX])
		else $error("sync overflow missed");

	idle_count_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE14
		idle_hit |=> flags[F_IDLE])
		else $error("idle hit not flagged");

	tick_ack_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE19
		tick_acknowledge && !tick_roll |=> !flags[F_TICK])
		else $error("tick acknowledge ignored");

	can_warn_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE22
		$rose(periph.can_rx_errors >= PIS_CAN_WARN) |=> flags[F_CRXW])
		else $error("can receive warning missed");

	group_status_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE23
		flags[F_TICK] && enable[F_TICK] |=> group_pending[16])
		else $error("tick group status wrong");

	flag_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE25
		flags[F_CONV] && !clr_vec[F_CONV] |=> flags[F_CONV])
		else $error("flag lost without clear");

	share_error_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE10
		flags[F_SFLT] && enable[F_SOVF] && !global_mask |=> cpu_request)
		else $error("select fault not on shared enable");

	master_fault_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE9
		select_fault_detect_on && periph.sync_master && !pin_s2[9] |=> flags[F_SFLT])
		else $error("master select fault missed");

	idle_restart_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE14
		periph.async_bit_tick && !pin_s2[10] |=> idle_count == 4'h0)
		else $error("idle count not restarted");

	conv_bit_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE17
		enable[F_CONV] |=> !conversion_done_bit)
		else $error("done bit shown while enabled");

	tick_set_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE18
		tick_roll |=> flags[F_TICK])
		else $error("tick rollover missed");

	bus_off_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE22
		periph.can_tx_errors > PIS_CAN_BUS_OFF && !can_level_prev[4] |=> flags[F_CBOFF])
		else $error("bus off missed");

	group_order_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE2
		next_groups[15] && !(|next_groups[14:1]) && !global_mask && !software_trap
		|=> cpu_priority == 5'h0f)
		else $error("lower number did not win");

endmodule // pis_top

/* sim/pis_core_model.sv */
// processor core stand-in: mask bit and trap pulse
module pis_core_model (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// bench commands
	input  wire logic mask_cmd,
	input  wire logic trap_cmd,
	// to collector
	output logic      global_mask,
	output logic      software_trap
);
	// =====
	// mask bit and one-cycle trap
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			global_mask   <= 1'b1;
			software_trap <= 1'b0;
		end else begin
			global_mask   <= mask_cmd;
			software_trap <= trap_cmd & ~software_trap;
		end
	end
endmodule // pis_core_model

/* sim/test_peripheral_interrupt_sources.sv */
// bench for the peripheral interrupt source collector
module test_peripheral_interrupt_sources;
	timeunit 1ns;
	timeprecision 1ps;
	import pis_pkg::*;
	// =====
	// signals
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic        ext_request_n = 1'b1;
	logic [7:0]  keypad_inputs = 8'hff;
	logic        select_in_n = 1'b1;
	logic        async_rx_pin = 1'b1;
	pis_periph_t periph;
	logic        mask_cmd = 1'b0;
	logic        trap_cmd = 1'b0;
	logic        global_mask;
	logic        software_trap;
	logic        cpu_request;
	logic [4:0]  cpu_priority;
	logic [20:1] group_pending;
	logic        conversion_done_bit;
	logic [33:0] fl;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          t;
	int          k;
	int          bt [14] = '{2, 3, 5, 6, 8, 11, 13, 14, 15, 16, 18, 21, 23, 30};

	always #10 ref_clk = ~ref_clk;

	pis_top dut (
		.ref_clk            (ref_clk),
		.reset              (reset),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_write          (reg_write),
		.reg_read           (reg_read),
		.reg_rdata          (reg_rdata),
		.ext_request_n      (ext_request_n),
		.keypad_inputs      (keypad_inputs),
		.select_in_n        (select_in_n),
		.async_rx_pin       (async_rx_pin),
		.periph             (periph),
		.global_mask        (global_mask),
		.software_trap      (software_trap),
		.cpu_request        (cpu_request),
		.cpu_priority       (cpu_priority),
		.group_pending      (group_pending),
		.conversion_done_bit(conversion_done_bit)
	);

	pis_core_model core (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.mask_cmd     (mask_cmd),
		.trap_cmd     (trap_cmd),
		.global_mask  (global_mask),
		.software_trap(software_trap)
	);

	// =====
	// tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(logic [33:0] e, logic [33:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rdr(logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task automatic getf;
		rdr(PIS_FLAGS_LO_ADDR);
		fl[31:0] = rd;
		rdr(PIS_FLAGS_HI_ADDR);
		fl[33:32] = rd[1:0];
	endtask

	task automatic clr;
		wr(PIS_FLAGS_LO_ADDR, 32'hffff_ffff);
		wr(PIS_FLAGS_HI_ADDR, 32'h0000_0003);
	endtask

	function automatic pis_periph_t evm(int i);
		pis_periph_t p;
		p = '0;
		case (i)
			0: p.channel_event[0][0] = 1'b1;
			1: p.channel_event[0][1] = 1'b1;
			2: p.channel_event[1][0] = 1'b1;
			3: p.channel_event[1][1] = 1'b1;
			4: p.sync_byte_done = 1'b1;
			5: p.sync_tx_load = 1'b1;
			6: p.async_noise = 1'b1;
			7: {p.async_stop_sample, p.async_stop_bit} = 2'h3;
			8: p.async_parity_err = 1'b1;
			9: p.async_char_done = 1'b1;
			10: p.async_tx_load = 1'b1;
			11: p.conversion_done = 1'b1;
			12: p.can_wake_activity = 1'b1;
			13: p.can_msg_stored = 1'b1;
			14: p.can_msg_arriving = 1'b1;
			default: p.async_bit_tick = 1'b1;
		endcase
		return p;
	endfunction

	task automatic ev(int i);
		@(posedge ref_clk);
		periph <= periph ^ evm(i);
		@(posedge ref_clk);
		periph <= periph ^ evm(i);
	endtask

	// =====
	// watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		complete_run();
	end

	// =====
	// tests
	initial begin
		periph = '0;
		periph.timer_modulo = '1;
		periph.async_stop_bit = 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		for (k = 0; k < 28; k += 4) begin
			rdr(8'(k));
			chk(34'h0, 34'(rd));
		end
		chk(34'h1f, 34'(cpu_priority));
		$display("test reset done");
		for (k = 0; k < 14; k++) begin
			clr();
			ev(k);
			cyc(3);
			getf();
			chk(34'h1 << bt[k], fl);
			cyc(6);
			getf();
			chk(34'h1 << bt[k], fl);
		end
		clr();
		ev(4);
		ev(4);
		ev(9);
		ev(9);
		cyc(3);
		getf();
		chk(34'h1_1300, fl);
		$display("test events done");
		clr();
		ext_request_n <= 1'b0;
		keypad_inputs[5] <= 1'b0;
		cyc(3);
		ext_request_n <= 1'b1;
		keypad_inputs <= 8'hff;
		cyc(6);
		getf();
		chk(34'h10_0001, fl);
		for (t = 0; t < 2; t++) begin
			clr();
			periph.lock <= ~periph.lock;
			cyc(4);
			getf();
			chk(34'h2, fl);
		end
		for (t = 0; t < 2; t++) begin
			clr();
			periph.timer_modulo[t] <= 16'h0005;
			periph.timer_count[t] <= 16'h0005;
			cyc(1);
			periph.timer_count[t] <= 16'h0000;
			cyc(3);
			getf();
			chk(34'h1 << (4 + 3 * t), fl);
		end
		$display("test pins timers done");
		clr();
		periph.sync_master <= 1'b1;
		select_in_n <= 1'b0;
		cyc(5);
		getf();
		chk(34'h0, fl);
		wr(PIS_CONTROL_ADDR, 32'h0000_0008);
		cyc(3);
		getf();
		chk(34'h400, fl);
		wr(PIS_ENABLE_LO_ADDR, 32'h0000_0200);
		cyc(2);
		chk(34'h100, 34'(group_pending));
		periph.sync_master <= 1'b0;
		periph.sync_active <= 1'b1;
		clr();
		getf();
		chk(34'h0, fl);
		select_in_n <= 1'b1;
		cyc(5);
		getf();
		chk(34'h400, fl);
		periph.sync_active <= 1'b0;
		wr(PIS_CONTROL_ADDR, 32'h0000_0000);
		periph.async_shift_empty <= 1'b1;
		periph.async_data_empty <= 1'b1;
		periph.async_break_idle <= 1'b1;
		clr();
		cyc(3);
		getf();
		chk(34'h0, fl);
		periph.async_break_idle <= 1'b0;
		cyc(3);
		getf();
		chk(34'h8_0000, fl);
		periph.async_shift_empty <= 1'b0;
		clr();
		repeat (9) ev(15);
		cyc(3);
		getf();
		chk(34'h0, fl);
		ev(15);
		cyc(3);
		getf();
		chk(34'h2_0000, fl);
		wr(PIS_CONTROL_ADDR, 32'h0000_0010);
		async_rx_pin <= 1'b0;
		cyc(3);
		ev(15);
		async_rx_pin <= 1'b1;
		cyc(3);
		clr();
		repeat (10) ev(15);
		cyc(3);
		getf();
		chk(34'h0, fl);
		ev(15);
		cyc(3);
		getf();
		chk(34'h2_0000, fl);
		$display("test serial done");
		clr();
		periph.can_rx_errors <= 8'h5f;
		cyc(3);
		getf();
		chk(34'h0, fl);
		periph.can_rx_errors <= 8'h60;
		cyc(3);
		getf();
		chk(34'h100_0000, fl);
		periph.can_rx_errors <= 8'h7f;
		cyc(3);
		getf();
		chk(34'h100_0000, fl);
		periph.can_rx_errors <= 8'h80;
		periph.can_tx_errors <= 9'h0ff;
		cyc(3);
		getf();
		chk(34'hf00_0000, fl);
		periph.can_tx_errors <= 9'h100;
		periph.can_tx_empty <= 3'h5;
		periph.can_fg_full <= 1'b1;
		periph.can_bg_full <= 1'b1;
		ev(14);
		cyc(3);
		getf();
		chk(34'h2_bf00_0000, fl);
		periph.can_tx_empty <= 3'h0;
		clr();
		getf();
		chk(34'h0, fl);
		$display("test can done");
		ev(11);
		cyc(3);
		chk(34'h1, 34'(conversion_done_bit));
		wr(PIS_ENABLE_LO_ADDR, 32'h4020_0000);
		cyc(2);
		chk(34'({conversion_done_bit, cpu_request, cpu_priority, group_pending}),
			34'({1'b0, 1'b1, 5'h0f, 20'h0_4000}));
		ev(13);
		cyc(2);
		chk(34'({cpu_request, cpu_priority, group_pending}),
			34'({1'b1, 5'h0f, 20'h4_4000}));
		mask_cmd <= 1'b1;
		cyc(3);
		chk(34'({cpu_request, cpu_priority, group_pending}),
			34'({1'b0, 5'h1f, 20'h4_4000}));
		@(posedge ref_clk);
		trap_cmd <= 1'b1;
		@(posedge ref_clk);
		trap_cmd <= 1'b0;
		cyc(1);
		chk(34'({cpu_request, cpu_priority}), 34'({1'b1, 5'h00}));
		$display("test priority done");
		wr(PIS_ENABLE_LO_ADDR, 32'h0040_0000);
		wr(PIS_CONTROL_ADDR, 32'h0000_0007);
		for (k = 0; k < 600 && group_pending[16] !== 1'b1; k++)
			cyc(1);
		chk(34'h1, 34'(group_pending[16]));
		clr();
		getf();
		chk(34'h40_0000, fl);
		wr(PIS_CONTROL_ADDR, 32'h0000_0027);
		getf();
		chk(34'h0, fl);
		rdr(PIS_CONTROL_ADDR);
		chk(34'h7, 34'(rd));
		$display("test tick done");
		complete_run();
	end
endmodule // test_peripheral_interrupt_sources
